// [dv/src_pin_partner.sv]
// Model of the external reset line, its pull-up and the other devices that share it.
`timescale 1ns/1ps
`default_nettype none
module src_pin_partner (
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic hold_low,
  output logic pin_level
);
  // Open-drain line: any party pulling low wins, otherwise the pull-up holds it high.
  assign pin_level = ((pin_oe && !pin_out) || hold_low) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// [dv/system_reset_controller_tb_top.sv]
// Self-checking bench for the reset sequencer, with random and corner cases.
`timescale 1ns/1ps
`default_nettype none
module system_reset_controller_tb_top;
  import src_pkg::*;
  localparam logic [31:0] KEYW = {CMD_KEY, 24'h0};
  logic pclk, presetn, slow_tick, psel, penable, pwrite, pready, pslverr, errv, sel;
  logic backup_good, core_good, pin_level, boot_pin, wdog_fault, wd_en, wd_cpu, hold_low;
  logic pin_out, pin_oe, cpu_clk_en, boot_select, irq, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, mval;
  logic [1:0] tdiv;
  src_rst_s rst_out;
  int seed, bad_count, total_checks, n, m;

  src_reset_sequencer #(.STARTUP_TICKS(4)) u_src_reset_sequencer (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .slow_tick(slow_tick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .backup_good(backup_good),
    .core_good(core_good), .pin_in(pin_level), .boot_select_pin(boot_pin),
    .wdog_fault(wdog_fault), .wdog_reset_enable(wd_en), .wdog_cpu_only_select(wd_cpu),
    .rst_out(rst_out), .pin_out(pin_out), .pin_oe(pin_oe), .cpu_clk_en(cpu_clk_en),
    .boot_select(boot_select), .irq(irq)
  );
  src_pin_partner u_src_pin_partner (
    .pin_oe(pin_oe), .pin_out(pin_out), .hold_low(hold_low), .pin_level(pin_level)
  );

  // Clock at 100 MHz.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Slow clock enable, one pulse every four cycles.
  initial tdiv = 2'h0;
  always @(posedge pclk) begin
    tdiv <= tdiv + 2'h1;
    slow_tick <= (tdiv == 2'h3);
  end

  // Closing report and verdict.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout;
    bad_count++;
    $display("unexpected at %0t: got %h expected %h", $time, n, 32'h0);
    print_verdict();
  endtask

  // One APB transfer; the request holds until pready is sampled high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 40) timeout();
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return rst_out.cpu_n;
      1: return rst_out.periph_n;
      2: return pin_oe;
      default: return irq;
    endcase
  endfunction

  // Bounded wait for a watched output to reach a level; n holds the cycles taken.
  task automatic wait_for(input int s, input logic lvl, input int lim);
    n = 0;
    @(negedge pclk);
    while (pick(s) !== lvl && n < lim) begin
      @(negedge pclk);
      n++;
    end
    if (n >= lim) timeout();
  endtask

  task automatic read_cause(input logic [2:0] exp);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdv[STS_CAUSE_LSB +: 3], exp);
  endtask

  // Main sequence.
  initial begin
    seed = 64484;
    bad_count = 0;
    total_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, hold_low, wdog_fault, wd_en, wd_cpu} = 7'h0;
    {paddr, pwdata} = 44'h0;
    {backup_good, core_good} = 2'h3;
    clk_en = 1'b1;
    boot_pin = 1'($random(seed));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(0, 1'b1, 400);
    chk(boot_select, boot_pin);
    chk(rst_out, 4'hf);
    read_cause(CAUSE_GENERAL);
    wait_for(2, 1'b0, 100);
    apb(1'b0, ADDR_MODE, 32'h0);
    chk(rdv, MODE_RESET);
    mval = $random(seed);
    apb(1'b1, ADDR_MODE, mval);
    apb(1'b0, ADDR_MODE, 32'h0);
    chk(rdv, mval & MODE_MASK);
    apb(1'b0, 8'hfc, 32'h0);
    chk(errv, 1'b1);
    chk(rdv, 32'h0);
    // Wrong key leaves everything alone.
    apb(1'b1, ADDR_MODE, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h5a00_0001);
    repeat (20) @(posedge pclk);
    chk(rst_out, 4'hf);
    // Processor reset command, with a second command refused while busy.
    apb(1'b1, ADDR_CMD, KEYW | 32'h1);
    wait_for(0, 1'b0, 3);
    chk(rst_out.wdog_n, 1'b0);
    apb(1'b1, ADDR_CMD, KEYW | 32'h4);
    @(negedge pclk);
    chk(rst_out.periph_n, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdv[STS_BUSY_BIT], 1'b1);
    chk(rdv[STS_CAUSE_LSB +: 3], CAUSE_GENERAL);
    wait_for(0, 1'b1, 40);
    read_cause(CAUSE_SOFT);
    chk(rdv[STS_BUSY_BIT], 1'b0);
    // Peripheral and pin command with length 1; own pulse is no user reset.
    apb(1'b1, ADDR_MODE, 32'h101);
    apb(1'b1, ADDR_CMD, KEYW | 32'hc);
    wait_for(1, 1'b0, 3);
    m = 0;
    while (pin_oe === 1'b1 && n < 400) begin
      if (slow_tick === 1'b1) m++;
      @(negedge pclk);
      n++;
    end
    chk(m, 4);
    chk(rst_out.cpu_n, 1'b1);
    repeat (40) @(posedge pclk);
    read_cause(CAUSE_SOFT);
    // User reset held from outside past the pulse length.
    apb(1'b1, ADDR_MODE, 32'h1);
    hold_low <= 1'b1;
    wait_for(0, 1'b0, 20);
    chk(rst_out.periph_n, 1'b0);
    repeat (80) @(posedge pclk);
    chk(rst_out.cpu_n, 1'b0);
    read_cause(CAUSE_SOFT);
    hold_low <= 1'b0;
    wait_for(0, 1'b1, 60);
    chk(n >= 12, 1'b1);
    read_cause(CAUSE_USER);
    // Interrupt in place of user reset; one status read clears both flag and interrupt.
    apb(1'b1, ADDR_MODE, 32'h10);
    apb(1'b0, ADDR_STATUS, 32'h0);
    hold_low <= 1'b1;
    wait_for(3, 1'b1, 20);
    repeat (20) @(posedge pclk);
    chk(rst_out, 4'hf);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdv[STS_EDGE_BIT], 1'b1);
    chk(rdv[STS_LEVEL_BIT], 1'b0);
    hold_low <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdv[STS_LEVEL_BIT], 1'b1);
    chk({rdv[STS_EDGE_BIT], irq}, 2'h0);
    // Watchdog fault, disabled and then enabled with a random select.
    sel = 1'($random(seed));
    wd_cpu <= sel;
    wdog_fault <= 1'b1;
    @(posedge pclk);
    wdog_fault <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(rst_out, 4'hf);
    wd_en <= 1'b1;
    wdog_fault <= 1'b1;
    @(posedge pclk);
    wdog_fault <= 1'b0;
    wait_for(0, 1'b0, 10);
    chk(rst_out.periph_n, sel);
    wait_for(0, 1'b1, 40);
    read_cause(CAUSE_WDOG);
    // Watchdog fault during a software reset takes over.
    wd_cpu <= 1'b1;
    apb(1'b1, ADDR_CMD, KEYW | 32'h1);
    wdog_fault <= 1'b1;
    @(posedge pclk);
    wdog_fault <= 1'b0;
    wait_for(0, 1'b1, 60);
    read_cause(CAUSE_WDOG);
    // Clock enable low freezes a running software reset.
    apb(1'b1, ADDR_CMD, KEYW | 32'h1);
    clk_en <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(rst_out.cpu_n, 1'b0);
    clk_en <= 1'b1;
    wait_for(0, 1'b1, 40);
    read_cause(CAUSE_SOFT);
    // Core supply loss and return.
    core_good <= 1'b0;
    repeat (12) @(posedge pclk);
    chk(rst_out, 4'h1);
    core_good <= 1'b1;
    wait_for(0, 1'b1, 100);
    read_cause(CAUSE_WAKE);
    // Backup supply loss asserts everything and clears the mode register.
    backup_good <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(rst_out, 4'h0);
    backup_good <= 1'b1;
    wait_for(0, 1'b1, 400);
    apb(1'b0, ADDR_MODE, 32'h0);
    chk(rdv, MODE_RESET);
    read_cause(CAUSE_GENERAL);
    print_verdict();
  end
endmodule
`default_nettype wire

// [logic/src_pkg.sv]
// Constants, types and register layout for the system reset controller.
package src_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  // Command register fields.
  localparam int CMD_CPU_BIT = 0;
  localparam int CMD_PERIPH_BIT = 2;
  localparam int CMD_PIN_BIT = 3;
  localparam int CMD_KEY_LSB = 24;
  localparam logic [7:0] CMD_KEY = 8'ha5;
  // Status register fields.
  localparam int STS_EDGE_BIT = 0;
  localparam int STS_CAUSE_LSB = 8;
  localparam int STS_LEVEL_BIT = 16;
  localparam int STS_BUSY_BIT = 17;
  // Mode register fields and reset value.
  localparam int MODE_UEN_BIT = 0;
  localparam int MODE_IRQ_BIT = 4;
  localparam int MODE_LEN_LSB = 8;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_MASK = 32'h0000_0f11;
  // Reset cause codes.
  localparam logic [2:0] CAUSE_GENERAL = 3'h0;
  localparam logic [2:0] CAUSE_WAKE = 3'h1;
  localparam logic [2:0] CAUSE_WDOG = 3'h2;
  localparam logic [2:0] CAUSE_SOFT = 3'h3;
  localparam logic [2:0] CAUSE_USER = 3'h4;
  // Sequence lengths in slow clock ticks, and the pulse counter width.
  localparam logic [15:0] CPU_START_TICKS = 16'h0003;
  localparam logic [15:0] RESYNC_TICKS = 16'h0002;
  localparam logic [15:0] SOFT_TICKS = 16'h0003;
  localparam logic [15:0] WDOG_TICKS = 16'h0003;
  localparam logic [1:0] BOOT_TICKS = 2'h3;
  localparam int STARTUP_TICKS_DEF = 64;
  localparam int PULSE_W = 17;

  // Sequencer states, one-hot.
  typedef enum logic [6:0] {
    ST_STARTUP = 7'h01,
    ST_WAKE = 7'h02,
    ST_CPUCLK = 7'h04,
    ST_IDLE = 7'h08,
    ST_SOFT = 7'h10,
    ST_WDOG = 7'h20,
    ST_USER = 7'h40
  } src_state_e;

  // Reset outputs, all active low.
  typedef struct packed {
    logic cpu_n;
    logic wdog_n;
    logic periph_n;
    logic backup_n;
  } src_rst_s;

  // Which resets a software or watchdog reset asserts.
  typedef struct packed {
    logic cpu;
    logic periph;
    logic pin;
  } src_mask_s;
endpackage

// [logic/src_reset_sequencer.sv]
// Reset sequencer with APB register access, pin pulse shaping and boot pin capture.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: The watchdog reset output always follows the processor reset output.
// RULE2: Sequencing advances on slow clock ticks and drives all four resets.
// RULE3: The reset pin is sampled per slow tick; a low level requests user reset.
// RULE4: With user reset disabled, a low pin level starts no reset.
// RULE5: A falling pin edge sets the edge flag; only a status read clears it.
// RULE6: The pin level bit shows the pin sampled on every clock edge.
// RULE7: Edge flag raises the interrupt when user reset is off and interrupt enabled.
// RULE8: A pin reset drives the pin low for 2^(length+1) slow ticks.
// RULE9: The boot pin is captured three slow ticks after core power rises.
// RULE10: The reset cause changes only when the processor reset releases.
// RULE11: General reset: startup count, 3 ticks with cpu clock, release, cause 0.
// RULE12: Backup supply loss asserts every reset output at once.
// RULE13: Core supply loss asserts all but backup; wake path reports cause 1.
// RULE14: User reset holds cpu and peripherals, exits after resync plus 3, cause 4.
// RULE15: User reset stays while the pin is held low from outside.
// RULE16: Command bits reset cpu, peripherals or pin, in any combination.
// RULE17: Software reset asserts at the write and releases after 3 slow ticks.
// RULE18: Pulses the block drives itself are never taken as user reset.
// RULE19: Software reset is recorded as cause only with the cpu bit set.
// RULE20: Busy flag covers a software reset; commands written meanwhile are ignored.
// RULE21: Enabled watchdog fault gives a 3-tick reset, cpu only or full.
// RULE22: Priority backup, core, watchdog, software, user; pin ignored in software reset.
// RULE23: A command write without key 0xa5 is dropped entirely.
module src_reset_sequencer
  import src_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int STARTUP_TICKS = STARTUP_TICKS_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic slow_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic backup_good,
  input wire logic core_good,
  input wire logic pin_in,
  input wire logic boot_select_pin,
  input wire logic wdog_fault,
  input wire logic wdog_reset_enable,
  input wire logic wdog_cpu_only_select,
  output var src_rst_s rst_out,
  output logic pin_out,
  output logic pin_oe,
  output logic cpu_clk_en,
  output logic boot_select,
  output logic irq
);

  src_state_e state_q, state_d;
  src_mask_s mask_q, mask_d;
  src_rst_s rst_q, rst_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0] cause_q, cause_d, pend_q, pend_d;
  logic [PULSE_W-1:0] pulse_q, pulse_d;
  logic [31:0] mode_q, prdata_q;
  logic [1:0] boot_cnt_q;
  logic pready_q, pslverr_q, self_q, pin_slow_q, level_q, flag_q, irq_q;
  logic drive_q, clk_q, boot_q, core_prev_q, load_pulse;

  // Bus decode; a transfer completes in the access cycle with pready high.
  wire setup = psel & ~penable;
  wire done = psel & penable & pready_q;
  wire sel_cmd = paddr == ADDR_W'(ADDR_CMD);
  wire sel_status = paddr == ADDR_W'(ADDR_STATUS);
  wire sel_mode = paddr == ADDR_W'(ADDR_MODE);
  wire mapped = sel_cmd | sel_status | sel_mode;
  wire wr_cmd = clk_en & done & pwrite & sel_cmd;
  wire wr_mode = clk_en & done & pwrite & sel_mode;
  wire rd_status = clk_en & done & ~pwrite & sel_status;
  wire key_ok = pwdata[CMD_KEY_LSB +: 8] == CMD_KEY; // RULE23
  wire [2:0] cmd_bits = {pwdata[CMD_CPU_BIT], pwdata[CMD_PERIPH_BIT], pwdata[CMD_PIN_BIT]};
  wire soft_go = wr_cmd & key_ok & (|cmd_bits) & (state_q == ST_IDLE); // RULE16 RULE20 RULE23

  // Mode fields and event conditions.
  wire user_en = mode_q[MODE_UEN_BIT];
  wire irq_en = mode_q[MODE_IRQ_BIT];
  wire [3:0] len = mode_q[MODE_LEN_LSB +: 4];
  wire tick = clk_en & slow_tick; // RULE2
  wire wdog_go = clk_en & wdog_fault & wdog_reset_enable; // RULE21
  wire user_go = tick & user_en & ~pin_slow_q & ~self_q; // RULE3 RULE4 RULE18
  wire pin_fall = level_q & ~pin_in;
  wire flag_d = (clk_en & pin_fall) | (flag_q & ~rd_status); // RULE5
  wire [PULSE_W-1:0] pulse_len = PULSE_W'(1) << ({1'b0, len} + 5'h01); // RULE8

  // Status word seen by software.
  wire [31:0] status_w = {14'h0000, state_q == ST_SOFT, level_q, 5'h00, cause_q, 7'h00, flag_q};

  // Sequencer next state, ordered by source priority.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cause_d = cause_q;
    pend_d = pend_q;
    mask_d = mask_q;
    load_pulse = 1'b0;
    if (!backup_good) begin // RULE12 RULE22
      state_d = ST_STARTUP;
      cnt_d = 16'h0000;
      pend_d = CAUSE_GENERAL;
    end else if (!core_good && state_q != ST_STARTUP) begin // RULE13 RULE22
      state_d = ST_WAKE;
      cnt_d = 16'h0000;
    end else begin
      case (state_q)
        ST_STARTUP: begin
          if (tick) begin // RULE11
            if (cnt_q == 16'(STARTUP_TICKS - 1)) begin
              state_d = ST_CPUCLK;
              cnt_d = 16'h0000;
              pend_d = CAUSE_GENERAL;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        ST_WAKE: begin
          if (tick) begin // RULE13
            if (cnt_q == RESYNC_TICKS - 16'h0001) begin
              state_d = ST_CPUCLK;
              cnt_d = 16'h0000;
              pend_d = CAUSE_WAKE;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        ST_CPUCLK: begin
          if (tick) begin // RULE11 RULE13
            if (cnt_q == CPU_START_TICKS - 16'h0001) begin
              state_d = ST_IDLE;
              cause_d = pend_q; // RULE10
              load_pulse = 1'b1;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        ST_IDLE: begin
          cnt_d = 16'h0000;
          if (wdog_go) begin // RULE21 RULE22
            state_d = ST_WDOG;
            mask_d = '{cpu: 1'b1, periph: ~wdog_cpu_only_select, pin: ~wdog_cpu_only_select};
            load_pulse = ~wdog_cpu_only_select;
          end else if (soft_go) begin // RULE16 RULE17
            state_d = ST_SOFT;
            mask_d = '{cpu: cmd_bits[2], periph: cmd_bits[1], pin: cmd_bits[0]};
            load_pulse = cmd_bits[0];
          end else if (user_go) begin // RULE3 RULE14
            state_d = ST_USER;
            mask_d = '{cpu: 1'b1, periph: 1'b1, pin: 1'b0};
            load_pulse = 1'b1;
          end
        end
        ST_SOFT: begin
          if (wdog_go) begin // RULE22
            state_d = ST_WDOG;
            cnt_d = 16'h0000;
            mask_d = '{cpu: 1'b1, periph: ~wdog_cpu_only_select, pin: ~wdog_cpu_only_select};
            load_pulse = ~wdog_cpu_only_select;
          end else if (tick) begin // RULE17
            if (cnt_q == SOFT_TICKS - 16'h0001) begin
              state_d = ST_IDLE;
              if (mask_q.cpu) begin // RULE19
                cause_d = CAUSE_SOFT;
              end
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        ST_WDOG: begin
          if (tick) begin // RULE21
            if (cnt_q == WDOG_TICKS - 16'h0001) begin
              state_d = ST_IDLE;
              cause_d = CAUSE_WDOG;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        ST_USER: begin
          if (tick) begin // RULE14 RULE15
            if (!pin_slow_q) begin
              cnt_d = 16'h0000;
            end else if (cnt_q == RESYNC_TICKS + CPU_START_TICKS - 16'h0001) begin
              state_d = ST_IDLE;
              cause_d = CAUSE_USER;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        default: begin
          state_d = ST_STARTUP;
          cnt_d = 16'h0000;
        end
      endcase
    end
  end

  // Reset outputs follow the next state, so a command asserts them at once.
  wire in_pwr = state_d == ST_STARTUP || state_d == ST_WAKE || state_d == ST_CPUCLK;
  wire in_mask = state_d == ST_SOFT || state_d == ST_WDOG || state_d == ST_USER;
  wire cpu_on = in_pwr | (in_mask & mask_d.cpu);
  always_comb begin
    rst_d.cpu_n = ~cpu_on;
    rst_d.wdog_n = ~cpu_on; // RULE1
    rst_d.periph_n = ~(in_pwr | (in_mask & mask_d.periph));
    rst_d.backup_n = ~(state_d == ST_STARTUP ||
                       (state_d == ST_CPUCLK && pend_d == CAUSE_GENERAL)); // RULE11 RULE12
  end

  // Pin pulse length counter, counted in slow ticks.
  always_comb begin
    pulse_d = pulse_q;
    if (load_pulse) begin
      pulse_d = pulse_len; // RULE8
    end else if (tick && pulse_q != '0) begin
      pulse_d = pulse_q - PULSE_W'(1);
    end
  end

  wire drive_d = in_pwr | (pulse_d != '0); // RULE8 RULE11
  wire clk_d = ~(state_d == ST_STARTUP || state_d == ST_WAKE ||
                 (state_d == ST_USER && cnt_d < RESYNC_TICKS));

  // Sequencer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_STARTUP;
      cnt_q <= 16'h0000;
      cause_q <= CAUSE_GENERAL;
      pend_q <= CAUSE_GENERAL;
      mask_q <= '0;
      pulse_q <= '0;
      rst_q <= '0;
      drive_q <= 1'b1;
      clk_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cause_q <= cause_d;
      pend_q <= pend_d;
      mask_q <= mask_d;
      pulse_q <= pulse_d;
      rst_q <= rst_d;
      drive_q <= drive_d;
      clk_q <= clk_d;
    end
  end

  // Pin sampling, own-pulse marker and status flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_slow_q <= 1'b1;
      self_q <= 1'b0;
      level_q <= 1'b0; // The block pulls the pin low in reset, so no false edge follows.
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      if (slow_tick) begin
        pin_slow_q <= pin_in; // RULE3
      end
      if (load_pulse && state_d != ST_USER) begin
        self_q <= 1'b1; // RULE18
      end else if (tick && pulse_q == '0 && pin_slow_q) begin
        self_q <= 1'b0;
      end
      level_q <= pin_in; // RULE6
      flag_q <= flag_d; // RULE5
      irq_q <= flag_d & ~user_en & irq_en; // RULE7
    end
  end

  // Boot select capture three slow ticks after core power returns.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_prev_q <= 1'b0;
      boot_cnt_q <= 2'h0;
      boot_q <= 1'b0;
    end else if (clk_en) begin
      core_prev_q <= core_good;
      if (core_good && !core_prev_q) begin
        boot_cnt_q <= BOOT_TICKS; // RULE9
      end else if (slow_tick && boot_cnt_q != 2'h0) begin
        boot_cnt_q <= boot_cnt_q - 2'h1;
        if (boot_cnt_q == 2'h1) begin
          boot_q <= boot_select_pin; // RULE9
        end
      end
    end
  end

  // APB slave: ready one cycle after setup, mode register kept while backup holds.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      mode_q <= MODE_RESET;
    end else if (clk_en) begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_q <= sel_status ? status_w : (sel_mode ? mode_q : 32'h0000_0000);
      end
      if (!backup_good) begin
        mode_q <= MODE_RESET;
      end else if (wr_mode) begin
        mode_q <= pwdata & MODE_MASK;
      end
    end
  end

  // Outputs straight from flip-flops; the pin is open drain, driven low only.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rst_out = rst_q;
  assign pin_out = 1'b0;
  assign pin_oe = drive_q;
  assign cpu_clk_en = clk_q;
  assign boot_select = boot_q;
  assign irq = irq_q;

  // Checks on the sequencer.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wdog_follows_cpu_a: assert property (rst_out.wdog_n == rst_out.cpu_n) // RULE1
    else $error("watchdog reset differs from cpu reset");
  backup_loss_a: assert property (clk_en && !backup_good |=> // RULE12
    !rst_out.cpu_n && !rst_out.periph_n && !rst_out.backup_n && pin_oe)
    else $error("backup loss did not assert all resets");
  core_loss_a: assert property ( // RULE13
    clk_en && backup_good && !core_good && state_q != ST_STARTUP
    |=> !rst_out.cpu_n && !rst_out.periph_n && rst_out.backup_n)
    else $error("core loss reset set wrong");
  user_disabled_a: assert property ( // RULE4
    state_q == ST_IDLE && !user_en && clk_en && !wdog_go && !soft_go && backup_good &&
    core_good |=> state_q == ST_IDLE)
    else $error("user reset entered while disabled");
  edge_flag_a: assert property ( // RULE5
    (clk_en && pin_fall) || (flag_q && !rd_status) |=> flag_q)
    else $error("edge flag lost");
  level_bit_a: assert property (clk_en |=> level_q == $past(pin_in)) // RULE6
    else $error("pin level bit wrong");
  irq_clear_a: assert property (rd_status && !pin_fall |=> !irq) // RULE7
    else $error("status read did not clear interrupt");
  cause_release_a: assert property ($changed(cause_q) |-> $rose(rst_out.cpu_n)) // RULE10
    else $error("reset cause changed without cpu release");
  cmd_ignored_a: assert property ( // RULE20
    state_q == ST_SOFT && clk_en && !wdog_go |=> $stable(mask_q))
    else $error("command accepted while busy");
  bad_key_a: assert property ( // RULE23
    wr_cmd && !key_ok && state_q == ST_IDLE && !wdog_go && !user_go && backup_good &&
    core_good |=> state_q == ST_IDLE)
    else $error("command taken with wrong key");
  soft_assert_a: assert property ( // RULE17
    soft_go && !wdog_go && cmd_bits[2] && backup_good && core_good |=>
    !rst_out.cpu_n && state_q == ST_SOFT)
    else $error("software reset not asserted at write");

endmodule

`default_nettype wire
